// ### hw/lcdfc_core.v
/*
 * Frame timing core of a segment panel driver: clock division, frame
 * counter, counter event flag, buffered data transfer, direct bias.
 * Assumes the slow clock arrives as a level synchronous to clock and
 * that software keeps the frame divider still while the driver runs.
 */
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "lcdfc_regs.vh"

module lcdfc_core
(
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Slow clock level
    input wire lowFreqClock,
    // Analog controls
    output wire contrastRefGround,
    output wire panelSupplyBoost,
    output wire [4:0] contrastLevel,
    output wire [3:0] boostLevel,
    output wire boosterEnable,
    output reg boostUpdateTick,
    // Timing strobes and interrupt level
    output reg panelClockTick,
    output reg frame_begin_update,
    output reg counterEvent,
    output wire interrupt,
    // Driver side data
    output wire [159:0] drvSegData,
    output reg [31:0] drvAnimFirst,
    output reg [31:0] drvAnimSecond,
    output reg [31:0] drvBlinkAnim,
    output wire [127:0] segBiasCode,
    output wire [15:0] comBiasCode,
    output wire [23:0] comLevels
);

    // ==========================================================
    // Helpers
    function [6:0] lowMask;
        input [2:0] n;
        begin
            lowMask = 7'h7f >> (3'h7 - n);
            if (n == 3'h0)
            begin
                lowMask = 7'h00;
            end
        end
    endfunction

    function [3:0] frameLast;
        input [2:0] mux;
        begin
            case (mux)
                3'h0: frameLast = 4'h1;
                3'h1: frameLast = 4'h3;
                3'h2: frameLast = 4'h5;
                3'h3: frameLast = 4'h7;
                3'h4: frameLast = 4'hb;
                3'h5: frameLast = 4'hf;
                default: frameLast = 4'h1;
            endcase
        end
    endfunction

    function [2:0] levelCount;
        input [1:0] code;
        begin
            levelCount = {1'b0, code} + 3'h2;
        end
    endfunction

    // ==========================================================
    // Register file
    reg [31:0] ctrl_q;
    reg [31:0] disp_q;
    reg [31:0] bactrl_q;
    reg [31:0] animA_q;
    reg [31:0] animB_q;
    reg [31:0] clkCtrl_q;
    reg ien_q;
    reg flag_q;
    reg [31:0] segWord_q [0:4];
    reg [5:0] count_q;
    reg pending_q;
    reg [31:0] drvSeg_q [0:4];

    wire wrEn = psel & penable & pwrite;
    wire setupPh = psel & ~penable;
    wire [1:0] udMode = ctrl_q[`LCDFC_CTRL_UD_LO +: 2];
    wire direct = ctrl_q[`LCDFC_CTRL_DIRECT];
    wire isSeg = (paddr >= `LCDFC_OFF_SEGD0)
        && (paddr < `LCDFC_OFF_SEGD0 + 12'h010)
        && (paddr[1:0] == 2'h0);
    wire [1:0] segIdx = paddr[3:2];
    wire isSeg4 = (paddr == `LCDFC_OFF_SEGD4);
    wire bufWrite = wrEn & (isSeg | isSeg4
        | (paddr == `LCDFC_OFF_ANIMA) | (paddr == `LCDFC_OFF_ANIMB)
        | (paddr == `LCDFC_OFF_BACTRL));
    wire ifsWrite = wrEn & (paddr == `LCDFC_OFF_IFS);
    wire ifcWrite = wrEn & (paddr == `LCDFC_OFF_IFC);

    assign pready = 1'b1;

    always @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_q <= `LCDFC_RST_ZERO;
            disp_q <= `LCDFC_RST_DISP;
            bactrl_q <= `LCDFC_RST_ZERO;
            animA_q <= `LCDFC_RST_ZERO;
            animB_q <= `LCDFC_RST_ZERO;
            clkCtrl_q <= `LCDFC_RST_ZERO;
            ien_q <= 1'b0;
        end
        else if (wrEn)
        begin
            case (paddr)
                `LCDFC_OFF_CTRL: ctrl_q <= pwdata;
                `LCDFC_OFF_DISP: disp_q <= pwdata;
                `LCDFC_OFF_BACTRL: bactrl_q <= pwdata;
                `LCDFC_OFF_ANIMA: animA_q <= pwdata;
                `LCDFC_OFF_ANIMB: animB_q <= pwdata;
                `LCDFC_OFF_CLKCTRL: clkCtrl_q <= pwdata;
                `LCDFC_OFF_IEN: ien_q <= pwdata[`LCDFC_IF_EVT];
                default: ien_q <= ien_q;
            endcase
        end
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            segWord_q[0] <= `LCDFC_RST_ZERO;
            segWord_q[1] <= `LCDFC_RST_ZERO;
            segWord_q[2] <= `LCDFC_RST_ZERO;
            segWord_q[3] <= `LCDFC_RST_ZERO;
            segWord_q[4] <= `LCDFC_RST_ZERO;
        end
        else if (wrEn & isSeg)
        begin
            segWord_q[segIdx] <= pwdata;
        end
        else if (wrEn & isSeg4)
        begin
            segWord_q[4] <= pwdata;
        end
    end

    // Read data is captured in the setup phase, so no wait states
    always @(posedge clock)
    begin
        if (rst)
        begin
            prdata <= `LCDFC_RST_ZERO;
            pslverr <= 1'b0;
        end
        else if (setupPh)
        begin
            pslverr <= 1'b0;
            case (paddr)
                `LCDFC_OFF_CTRL: prdata <= ctrl_q;
                `LCDFC_OFF_DISP: prdata <= disp_q;
                `LCDFC_OFF_BACTRL: prdata <= bactrl_q;
                `LCDFC_OFF_STATUS: prdata <= {23'h0, pending_q, 2'h0, count_q};
                `LCDFC_OFF_ANIMA: prdata <= animA_q;
                `LCDFC_OFF_ANIMB: prdata <= animB_q;
                `LCDFC_OFF_IF: prdata <= {31'h0, flag_q};
                `LCDFC_OFF_IFS: prdata <= `LCDFC_RST_ZERO;
                `LCDFC_OFF_IFC: prdata <= `LCDFC_RST_ZERO;
                `LCDFC_OFF_IEN: prdata <= {31'h0, ien_q};
                `LCDFC_OFF_CLKCTRL: prdata <= clkCtrl_q;
                `LCDFC_OFF_SEGD4: prdata <= segWord_q[4];
                default:
                begin
                    if (isSeg)
                    begin
                        prdata <= segWord_q[segIdx];
                    end
                    else
                    begin
                        prdata <= `LCDFC_RST_ZERO;
                        pslverr <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Analog control levels
    assign contrastRefGround = disp_q[`LCDFC_DISP_CONREF];
    assign panelSupplyBoost = disp_q[`LCDFC_DISP_SUPPLY];
    assign contrastLevel = disp_q[`LCDFC_DISP_CONTRAST_LO +: 5];
    assign boostLevel = disp_q[`LCDFC_DISP_BLEV_LO +: 4];
    assign boosterEnable = clkCtrl_q[`LCDFC_CLK_BOOSTEN];

    // ==========================================================
    // Clock division chain
    reg lfLast_q;
    reg [6:0] lfCnt_q;
    reg [2:0] divCnt_q;
    reg [3:0] phase_q;
    reg [2:0] frameCnt_q;

    wire lfTick = lowFreqClock & ~lfLast_q;
    wire [6:0] bMask = lowMask(clkCtrl_q[`LCDFC_CLK_BDIV_LO +: 3]);
    wire [2:0] preSel = {1'b0, clkCtrl_q[`LCDFC_CLK_PRE_LO +: 2]} + 3'h4;
    wire [6:0] pMask = lowMask(preSel);
    wire preTick = lfTick & ((lfCnt_q & pMask) == pMask);
    wire [2:0] frameDiv = clkCtrl_q[`LCDFC_CLK_FRDIV_LO +: 3];
    wire running = ctrl_q[`LCDFC_CTRL_EN];
    wire divTick = preTick & (divCnt_q == frameDiv);
    wire [3:0] last = frameLast(disp_q[`LCDFC_DISP_MUX_LO +: 3]);
    wire frameTick = running & divTick & (phase_q == last);
    wire [6:0] fMask = lowMask({1'b0, bactrl_q[`LCDFC_BA_PRESC_LO +: 2]});
    wire cntTick = frameTick & ((frameCnt_q[2:0] & fMask[2:0]) == fMask[2:0]);
    wire cntOn = running & bactrl_q[`LCDFC_BA_CNTEN];
    wire evt = cntOn & cntTick & (count_q == 6'h00);

    always @(posedge clock)
    begin
        if (rst)
        begin
            lfLast_q <= 1'b0;
            lfCnt_q <= 7'h00;
            boostUpdateTick <= 1'b0;
            panelClockTick <= 1'b0;
            divCnt_q <= 3'h0;
        end
        else
        begin
            lfLast_q <= lowFreqClock;
            if (lfTick)
            begin
                lfCnt_q <= lfCnt_q + 7'h01;
            end
            boostUpdateTick <= lfTick & ((lfCnt_q & bMask) == bMask);
            // A divider move below the count restarts it at zero on the next prescaled tick
            if (preTick)
            begin
                divCnt_q <= (divCnt_q >= frameDiv) ? 3'h0
                    : divCnt_q + 3'h1;
            end
            panelClockTick <= divTick;
        end
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            phase_q <= 4'h0;
            frame_begin_update <= 1'b0;
        end
        else
        begin
            if (!running)
            begin
                phase_q <= 4'h0;
            end
            else if (divTick)
            begin
                phase_q <= (phase_q >= last) ? 4'h0 : phase_q + 4'h1;
            end
            frame_begin_update <= frameTick;
        end
    end

    // ==========================================================
    // Frame counter
    always @(posedge clock)
    begin
        if (rst)
        begin
            frameCnt_q <= 3'h0;
            count_q <= 6'h00;
            counterEvent <= 1'b0;
        end
        else
        begin
            counterEvent <= evt;
            if (!cntOn)
            begin
                frameCnt_q <= 3'h0;
                count_q <= bactrl_q[`LCDFC_BA_TOP_LO +: 6];
            end
            else
            begin
                if (frameTick)
                begin
                    frameCnt_q <= frameCnt_q + 3'h1;
                end
                if (cntTick)
                begin
                    if (count_q == 6'h00)
                    begin
                        count_q <= bactrl_q[`LCDFC_BA_TOP_LO +: 6];
                    end
                    else
                    begin
                        count_q <= count_q - 6'h01;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Event flag, set wins over clear
    always @(posedge clock)
    begin
        if (rst)
        begin
            flag_q <= 1'b0;
        end
        else if (evt | (ifsWrite & pwdata[`LCDFC_IF_EVT]))
        begin
            flag_q <= 1'b1;
        end
        else if (ifcWrite & pwdata[`LCDFC_IF_EVT])
        begin
            flag_q <= 1'b0;
        end
    end

    assign interrupt = flag_q & ien_q;

    // ==========================================================
    // Buffered transfer to the driver side
    // Mode 00 waits for the next driver tick so the copy never lands
    // between panel ticks; modes 01 and 10 copy at every counter event or frame start, and mode 11 acts as mode 00.
    reg doXfer;

    always @*
    begin
        case (udMode)
            `LCDFC_UD_REGULAR: doXfer = pending_q & divTick;
            `LCDFC_UD_EVENT: doXfer = evt;
            `LCDFC_UD_FRAME: doXfer = frameTick;
            default: doXfer = pending_q & divTick;
        endcase
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            pending_q <= 1'b0;
        end
        else if (bufWrite)
        begin
            pending_q <= 1'b1;
        end
        else if (doXfer)
        begin
            pending_q <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : gSeg
            always @(posedge clock)
            begin
                if (rst)
                begin
                    drvSeg_q[gi] <= `LCDFC_RST_ZERO;
                end
                else if (doXfer)
                begin
                    drvSeg_q[gi] <= segWord_q[gi];
                end
            end
            assign drvSegData[32*gi +: 32] = drvSeg_q[gi];
        end
    endgenerate

    always @(posedge clock)
    begin
        if (rst)
        begin
            drvAnimFirst <= `LCDFC_RST_ZERO;
            drvAnimSecond <= `LCDFC_RST_ZERO;
            drvBlinkAnim <= `LCDFC_RST_ZERO;
        end
        else if (doXfer)
        begin
            drvAnimFirst <= animA_q;
            drvAnimSecond <= animB_q;
            drvBlinkAnim <= bactrl_q;
        end
    end

    // ==========================================================
    // Bias per line
    wire [1:0] cfgBias = disp_q[`LCDFC_DISP_BIAS_LO +: 2];
    wire [127:0] segWords = drvSegData[127:0];

    generate
        for (gi = 0; gi < 64; gi = gi + 1)
        begin : gSegBias
            assign segBiasCode[2*gi +: 2] =
                direct ? segWords[2*gi +: 2] : cfgBias;
        end
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : gComBias
            assign comBiasCode[2*gi +: 2] =
                direct ? drvSegData[128 + 2*gi +: 2] : cfgBias;
            assign comLevels[3*gi +: 3] =
                levelCount(comBiasCode[2*gi +: 2]);
        end
    endgenerate

endmodule // lcdfc_core

// ### hw/lcdfc_regs.vh
/*
 * Register offsets, field positions, reset values and update mode codes
 * of the panel frame timing core.
 * Assumes a 32-bit APB slave with byte addresses and a 200 MHz clock.
 */
// Summary of operation
// - Contrast referenced to supply or ground
// - Panel supply from main or booster
// - Booster update tick is slow clock/2^n
// - Prescale slow clock by 16/32/64/128
// - Divide prescaled clock by one plus divider
// - Frame length set by multiplex mode
// - Driver side runs on prescaled panel tick
// - Segment, animation, blink words are synchronised
// - Mode 00 transfers soon after write
// - Mode 01 transfers at counter event
// - Mode 10 transfers at every frame start
// - Direct control overrides bias from data words
// - Two bits per line, line order
// - Bias code gives two to five levels
// - Frame counter aligned to frame start
// - Counter event drives flag, blink, animation, update
// - Down counter runs only while enabled
// - Counter ticks every 1/2/4/8 frames
// - At zero reload top, raise event
// - Event rate is tick over top plus one
// - Flag set each event, enable gates interrupt
`ifndef LCDFC_REGS_VH
`define LCDFC_REGS_VH

// ==========================================================
// Offsets
`define LCDFC_OFF_CTRL 12'h000
`define LCDFC_OFF_DISP 12'h004
`define LCDFC_OFF_BACTRL 12'h00c
`define LCDFC_OFF_STATUS 12'h010
`define LCDFC_OFF_ANIMA 12'h014
`define LCDFC_OFF_ANIMB 12'h018
`define LCDFC_OFF_IF 12'h01c
`define LCDFC_OFF_IFS 12'h020
`define LCDFC_OFF_IFC 12'h024
`define LCDFC_OFF_IEN 12'h028
`define LCDFC_OFF_SEGD0 12'h040
`define LCDFC_OFF_SEGD4 12'h0cc
`define LCDFC_OFF_CLKCTRL 12'h070

// ==========================================================
// Fields
`define LCDFC_CTRL_EN 0
`define LCDFC_CTRL_UD_LO 1
`define LCDFC_CTRL_DIRECT 23
`define LCDFC_DISP_MUX_LO 0
`define LCDFC_DISP_BIAS_LO 4
`define LCDFC_DISP_CONTRAST_LO 8
`define LCDFC_DISP_CONREF 13
`define LCDFC_DISP_BLEV_LO 16
`define LCDFC_DISP_SUPPLY 20
`define LCDFC_BA_CNTEN 0
`define LCDFC_BA_PRESC_LO 1
`define LCDFC_BA_TOP_LO 8
`define LCDFC_CLK_PRE_LO 0
`define LCDFC_CLK_FRDIV_LO 4
`define LCDFC_CLK_BDIV_LO 8
`define LCDFC_CLK_BOOSTEN 12
`define LCDFC_IF_EVT 0

// ==========================================================
// Reset values and codes
`define LCDFC_RST_ZERO 32'h0000_0000
`define LCDFC_RST_DISP 32'h0000_1f00
`define LCDFC_UD_REGULAR 2'h0
`define LCDFC_UD_EVENT 2'h1
`define LCDFC_UD_FRAME 2'h2

`endif

// ### dv/lcdfc_fc_monitor.sv
/*
 * Port checker of the panel frame timing core.
 * Assumes one clock domain and one-cycle strobes.
 */
`timescale 1ns/1ps

module lcdfc_cnt_monitor
(
    // Clock and reset
    input logic clock,
    input logic rst,
    // Bus qualifiers
    input logic psel,
    input logic penable,
    input logic pwrite,
    // Observed outputs
    input logic contrastRefGround,
    input logic panelSupplyBoost,
    input logic boostUpdateTick,
    input logic panelClockTick,
    input logic frame_begin_update,
    input logic counterEvent,
    input logic interrupt,
    input logic [15:0] comBiasCode,
    input logic [23:0] comLevels
);
    // ==========
    // Timing relations
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    tick_spacing_a: assert property (
        panelClockTick |=> !panelClockTick [*8])
        else $error("panel tick too soon");
    boost_pulse_a: assert property (
        boostUpdateTick |=> !boostUpdateTick)
        else $error("boost tick longer than one cycle");
    frame_spacing_a: assert property (
        frame_begin_update |=> !frame_begin_update [*8])
        else $error("frame too short");
    event_aligned_a: assert property (
        counterEvent |-> frame_begin_update || $past(frame_begin_update)
            || $past(frame_begin_update, 2) || $past(frame_begin_update, 3))
        else $error("event away from frame end");
    event_spacing_a: assert property (
        counterEvent |=> !counterEvent [*8])
        else $error("events too close");
    com_levels_a: assert property (
        comLevels[2:0] == {1'b0, comBiasCode[1:0]} + 3'h2)
        else $error("level count does not match code");
    ref_hold_a: assert property (
        !(psel && penable && pwrite) |=> $stable(contrastRefGround)
            && $stable(panelSupplyBoost))
        else $error("analog select moved without write");
    irq_cause_a: assert property (
        $rose(interrupt) |-> $past(psel && penable && pwrite)
            or $past(counterEvent) or ##[0:1] counterEvent)
        else $error("interrupt rose without cause");
endmodule // lcdfc_cnt_monitor

// ### dv/lcdfc_panel_model.sv
/*
 * Slow clock source on the panel side of the core.
 * Assumes the core samples the slow clock as a level on clock.
 */
`timescale 1ns/1ps

module lcdfc_panel_model
(
    // Clock and reset
    input logic clock,
    input logic rst,
    // Slow clock to the core
    output logic lowFreqClock
);
    // ==========
    // Oscillator
    // Fastest rate the edge detector resolves, keeps the run short
    always @(posedge clock)
    begin
        if (rst)
            lowFreqClock <= 1'b0;
        else
            lowFreqClock <= !lowFreqClock;
    end
endmodule // lcdfc_panel_model

// ### dv/tb_top.sv
/*
 * Self-checking bench of the panel frame timing core.
 * Assumes zero-wait APB answers and a slow edge every two cycles.
 */
`timescale 1ns/1ps
`define CMP(a, e) \
    begin \
        n_compared++; \
        if ((a) !== (e)) \
        begin \
            failures++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end

module tb_top;
    // ==========
    // Signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic probe = 1'b0;
    logic [31:0] obs = 32'h0;
    logic [31:0] lfsr = 32'h0000_8749;
    logic [31:0] expd;
    logic [31:0] q[$];
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    wire pready, pslverr, lowFreqClock, contrastRefGround, panelSupplyBoost;
    wire boosterEnable, boostUpdateTick, panelClockTick, frame_begin_update;
    wire counterEvent, interrupt;
    wire [31:0] prdata, drvAnimFirst, drvAnimSecond, drvBlinkAnim;
    wire [4:0] contrastLevel;
    wire [3:0] boostLevel;
    wire [159:0] drvSegData;
    wire [127:0] segBiasCode;
    wire [15:0] comBiasCode;
    wire [23:0] comLevels;

    lcdfc_core dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .lowFreqClock(lowFreqClock), .contrastRefGround(contrastRefGround),
        .panelSupplyBoost(panelSupplyBoost), .contrastLevel(contrastLevel),
        .boostLevel(boostLevel), .boosterEnable(boosterEnable),
        .boostUpdateTick(boostUpdateTick), .panelClockTick(panelClockTick),
        .frame_begin_update(frame_begin_update), .counterEvent(counterEvent),
        .interrupt(interrupt), .drvSegData(drvSegData),
        .drvAnimFirst(drvAnimFirst), .drvAnimSecond(drvAnimSecond),
        .drvBlinkAnim(drvBlinkAnim), .segBiasCode(segBiasCode),
        .comBiasCode(comBiasCode), .comLevels(comLevels));
    lcdfc_panel_model panel (.clock(clock), .rst(rst),
        .lowFreqClock(lowFreqClock));

    always #2.5 clock = !clock;

    // ==========
    // Watcher and limit
    always @(posedge clock)
    begin
        if (probe || (psel && penable && !pwrite && pready))
        begin
            expd = q.pop_front();
            `CMP(probe ? obs : prdata, expd)
        end
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 32'h0000_9c40)
        begin
            failures++;
            final_report();
        end
    end

    // ==========
    // Tasks
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic sig(input int s);
        case (s)
            0: return panelClockTick;
            1: return frame_begin_update;
            2: return counterEvent;
            default: return boostUpdateTick;
        endcase
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task chk(input logic [31:0] a, input logic [31:0] e);
        q.push_back(e);
        obs <= a;
        probe <= 1'b1;
        @(posedge clock);
        probe <= 1'b0;
        @(posedge clock);
    endtask
    task waitp(input int s);
        do @(posedge clock); while (sig(s) !== 1'b1);
    endtask
    // Skips one pulse so a setting change cannot shorten the measure
    task gap(input int s, output int n);
        waitp(s);
        waitp(s);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (sig(s) !== 1'b1);
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========
    // Sequence
    initial
    begin
        int n;
        int fl[6];
        logic [31:0] v;
        logic [31:0] w;
        logic [2:0] lv;
        fl = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10};
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(12'h004, 32'h0000_1f00);
        rd(12'h008, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        wr(12'h004, 32'h001a_2d00);
        rd(12'h004, 32'h001a_2d00);
        chk({21'h0, contrastRefGround, panelSupplyBoost, boostLevel,
            contrastLevel}, 32'h0000_074d);
        for (int p = 0; p < 4; p++)
        begin
            wr(12'h070, p | (p << 4) | ((2 * p + 1) << 8));
            gap(0, n);
            chk(n, (32'h20 << p) * (1 + p));
            gap(3, n);
            chk(n, 32'h2 << (2 * p + 1));
        end
        wr(12'h070, 32'h0000_1000);
        chk({31'h0, boosterEnable}, 32'h1);
        wr(12'h000, 32'h1);
        for (int m = 0; m < 6; m++)
        begin
            wr(12'h004, m);
            gap(1, n);
            chk(n, fl[m] * 32'h20);
        end
        wr(12'h004, 32'h0);
        wr(12'h00c, 32'h0000_0500);
        waitp(0);
        waitp(0);
        rd(12'h010, 32'h0000_0005);
        for (int p = 3; p >= 0; p--)
        begin
            wr(12'h00c, 32'h0000_0101 | (p << 1));
            gap(2, n);
            chk(n, 32'h80 << p);
        end
        waitp(2);
        rd(12'h01c, 32'h1);
        chk({31'h0, interrupt}, 32'h0);
        wr(12'h028, 32'h1);
        chk({31'h0, interrupt}, 32'h1);
        wr(12'h024, 32'h1);
        rd(12'h01c, 32'h0);
        wr(12'h020, 32'h1);
        rd(12'h01c, 32'h1);
        wr(12'h024, 32'h1);
        waitp(2);
        waitp(0);
        rd(12'h01c, 32'h1);
        wr(12'h028, 32'h0);
        wr(12'h000, 32'h3);
        waitp(2);
        v = rnd();
        wr(12'h040, v);
        wr(12'h018, ~v);
        chk(drvSegData[31:0], 32'h0);
        chk(drvAnimSecond, 32'h0);
        waitp(2);
        @(posedge clock);
        chk(drvSegData[31:0], v);
        chk(drvAnimSecond, ~v);
        chk(drvBlinkAnim, 32'h0000_0101);
        w = v;
        wr(12'h000, 32'h5);
        waitp(1);
        v = rnd();
        wr(12'h040, v);
        wr(12'h014, v);
        waitp(0);
        @(posedge clock);
        chk(drvSegData[31:0], w);
        waitp(1);
        @(posedge clock);
        chk(drvSegData[31:0], v);
        chk(drvAnimFirst, v);
        w = 32'h0000_e4e4;
        wr(12'h000, 32'h0080_0001);
        wr(12'h0cc, w);
        repeat (2)
        begin
            v = rnd();
            wr(12'h040, v);
            wr(12'h04c, ~v);
            waitp(0);
            waitp(0);
            @(posedge clock);
            chk(drvSegData[31:0], v);
            chk(segBiasCode[31:0], v);
            chk(drvSegData[127:96], ~v);
            chk(segBiasCode[127:96], ~v);
            chk({16'h0, comBiasCode}, w);
            for (int i = 0; i < 8; i++)
            begin
                lv = {1'b0, w[2 * i +: 2]} + 3'h2;
                chk({29'h0, comLevels[3 * i +: 3]}, {29'h0, lv});
            end
        end
        wr(12'h000, 32'h1);
        wr(12'h004, 32'h0000_0020);
        chk(segBiasCode[31:0], 32'haaaa_aaaa);
        chk({16'h0, comBiasCode}, 32'h0000_aaaa);
        final_report();
    end
endmodule // tb_top

bind lcdfc_core lcdfc_cnt_monitor mon (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .contrastRefGround(contrastRefGround),
    .panelSupplyBoost(panelSupplyBoost), .boostUpdateTick(boostUpdateTick),
    .panelClockTick(panelClockTick), .frame_begin_update(frame_begin_update),
    .counterEvent(counterEvent), .interrupt(interrupt),
    .comBiasCode(comBiasCode), .comLevels(comLevels));
